/* File: bench/accu_irq_cmd_asserts.sv */
// Concurrent checks on the command unit ports
`timescale 1ns/1ps
`include "accu_cmd_defs.vh"
module accu_irq_cmd_asserts (
  input wire                   clock,
  input wire                   rst,
  input wire                   psel,
  input wire                   penable,
  input wire                   pwrite,
  input wire [7:0]             paddr,
  input wire [31:0]            pwdata,
  input wire [`ERR_FLAG_N-1:0] err_set,
  input wire                   axis_wr_stb,
  input wire [7:0]             axis_wr_param,
  input wire [7:0]             axis_wr_motor,
  input wire [31:0]            axis_wr_data,
  input wire                   glob_wr_stb,
  input wire [7:0]             glob_wr_param,
  input wire [7:0]             glob_wr_bank,
  input wire [`ERR_FLAG_N-1:0] err_flags,
  input wire                   in_handler
);
  // ----------------------------------------------------------------
  // Command decode seen at the access edge
  // ----------------------------------------------------------------
  wire       cmd_w = psel & penable & pwrite & (paddr == `REG_CMD);
  wire [7:0] op    = pwdata[7:0];
  wire [7:0] ty    = pwdata[15:8];
  wire [7:0] bank  = pwdata[23:16];
  wire       ax_w  = cmd_w & (op == `OP_ACCU_TO_AXIS);
  wire       gl_w  = cmd_w & (op == `OP_ACCU_TO_GLOBAL);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  axis_write_a:
  assert property (ax_w |=> axis_wr_stb && axis_wr_param == $past(ty) && axis_wr_motor == $past(bank))
    else $error("axis write not issued");
  axis_cause_a:
  assert property (axis_wr_stb |-> $past(ax_w)) else $error("axis strobe without command");
  axis_pulse_a:
  assert property (axis_wr_stb |=> !axis_wr_stb) else $error("axis strobe too long");
  axis_hold_a:
  assert property ($changed(axis_wr_data) |-> axis_wr_stb) else $error("axis data moved alone");
  glob_write_a:
  assert property (gl_w && bank inside {8'h00, 8'h02, 8'h03}
    |=> glob_wr_stb && glob_wr_param == $past(ty) && glob_wr_bank == $past(bank))
    else $error("global write not issued");
  glob_refuse_a:
  assert property (gl_w && !(bank inside {8'h00, 8'h02, 8'h03}) |=> !glob_wr_stb)
    else $error("bad bank written");
  clear_all_a:
  assert property (cmd_w && op == `OP_CLEAR_ERRORS && ty == `CLR_ALL && err_set == '0 |=> err_flags == '0)
    else $error("flags not all cleared");
  clear_one_a:
  assert property (cmd_w && op == `OP_CLEAR_ERRORS && ty inside {[8'h01:8'h05]} && err_set == '0
    |=> err_flags == ($past(err_flags) & ~(5'h01 << ($past(ty) - 8'h01))))
    else $error("wrong flag cleared");
  flag_sticky_a:
  assert property (err_set != '0 |=> (err_flags & $past(err_set)) == $past(err_set))
    else $error("error flag lost");
  handler_ret_a:
  assert property (cmd_w && op == `OP_RETURN_HANDLER && in_handler |=> !in_handler)
    else $error("handler not left");
  entry_gap_a:
  assert property ($rose(in_handler) |-> !$past(cmd_w)) else $error("entry during command");

  cover property (axis_wr_stb);
  cover property (glob_wr_stb);
  cover property ($rose(in_handler));
endmodule // accu_irq_cmd_asserts

bind accu_irq_cmd_unit accu_irq_cmd_asserts i_chk (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .err_set, .axis_wr_stb, .axis_wr_param, .axis_wr_motor, .axis_wr_data, .glob_wr_stb, .glob_wr_param,
  .glob_wr_bank, .err_flags, .in_handler);

/* File: bench/cmd_host.sv */
// APB host model that issues commands to the unit
`timescale 1ns/1ps
`include "accu_cmd_defs.vh"
module cmd_host (
  input  wire         clock,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  input  wire  [31:0] prdata,
  input  wire         pready,
  input  wire         pslverr
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle bus shows junk so a stale value never looks valid
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask
  task cmd(input logic [31:0] acc, input logic [31:0] val, input logic [7:0] op, input logic [7:0] ty,
           input logic [7:0] bk);
    wr(`REG_ACCU, acc);
    wr(`REG_VALUE, val);
    wr(`REG_CMD, {8'h00, bk, ty, op});
  endtask
endmodule // cmd_host

/* File: bench/tb.sv */
// Self-checking testbench for the command unit
`timescale 1ns/1ps
`include "accu_cmd_defs.vh"
module tb;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic [15:0] irq_req;
  logic [4:0]  err_set;
  wire         psel, penable, pwrite, pready, pslverr, axis_wr_stb, glob_wr_stb, in_handler, irq;
  wire [7:0]   paddr, axis_wr_param, axis_wr_motor, glob_wr_param, glob_wr_bank;
  wire [31:0]  pwdata, prdata, axis_wr_data, glob_wr_data;
  wire [4:0]   err_flags;
  wire [15:0]  prog_counter;
  int          n_fail = 0;
  int          samples_checked = 0;
  // Rows: opcode, type, bank, expected status
  logic [31:0] rows [0:21] = '{32'h22040064, 32'h22070164, 32'h232a0264, 32'h23050064, 32'h23090364,
    32'h23010104, 32'h24000064, 32'h24010764, 32'h24020064, 32'h24030064, 32'h24040064, 32'h24050064,
    32'h24060003, 32'h19030064, 32'h19ff0064, 32'h1a030064, 32'h1aff0064, 32'h19100003, 32'h25020064,
    32'h25100003, 32'h26000002, 32'h27000002};

  always #5 clock = ~clock;

  accu_irq_cmd_unit i_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .irq_req, .err_set, .axis_wr_stb, .axis_wr_param, .axis_wr_motor, .axis_wr_data, .glob_wr_stb,
    .glob_wr_param, .glob_wr_bank, .glob_wr_data, .err_flags, .prog_counter, .in_handler, .irq);
  cmd_host i_host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    i_host.rd(a, q, e);
    chk(q, exp);
  endtask
  task settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task pulse_src(input int k);
    @(posedge clock);
    irq_req[k] <= 1'b1;
    @(posedge clock);
    irq_req <= '0;
  endtask
  task give_verdict;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    give_verdict;
  end

  initial begin
    logic [31:0] r, acc, q;
    logic        e;
    irq_req = '0;
    err_set = '0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rchk(`REG_REPLY, 32'h0);
    for (int i = 0; i < 22; i++) begin
      r = rows[i];
      acc = 32'h1357_0000 + i;
      i_host.cmd(acc, 32'h0, r[31:24], r[23:16], r[15:8]);
      settle(1);
      rchk(`REG_REPLY, {16'h0, r[31:24], r[7:0]});
      if (r[31:24] == `OP_ACCU_TO_AXIS) chk(axis_wr_data, acc);
      if (r[31:24] == `OP_ACCU_TO_GLOBAL && r[7:0] == `STATUS_OK) chk(glob_wr_data, acc);
    end
    for (int t = 0; t < 6; t++) begin
      @(posedge clock);
      err_set <= 5'h1f;
      @(posedge clock);
      err_set <= 5'h00;
      i_host.cmd(0, 32'h9, `OP_CLEAR_ERRORS, t[7:0], 8'h07);
      settle(1);
      chk(err_flags, t == 0 ? 32'h0 : 32'h1f & ~(32'h1 << (t - 1)));
    end
    rchk(`REG_EVT_STATUS, 32'h3);
    rchk(`REG_EVT_STATUS, 32'h0);
    i_host.wr(`REG_EVT_MASK, 32'h4);
    i_host.wr(`REG_PROG_COUNTER, 32'h77);
    i_host.wr(`REG_XREG, 32'h5a5a);
    i_host.wr(`REG_COND_FLAGS, 32'h3c);
    i_host.cmd(0, 32'h123, `OP_DEFINE_ENTRY, 8'h02, 8'h00);
    i_host.cmd(0, 32'h456, `OP_DEFINE_ENTRY, 8'h02, 8'h00);
    i_host.cmd(0, 32'h0, `OP_IRQ_ENABLE, 8'h02, 8'h00);
    rchk(`REG_IRQ_CTRL, 32'h0004_0000);
    pulse_src(2);
    settle(3);
    chk(in_handler, 1'b0);
    chk(irq, 1'b0);
    i_host.cmd(32'hacce55, 32'h0, `OP_IRQ_ENABLE, `IRQ_GLOBAL_NUM, 8'h00);
    settle(2);
    chk(in_handler, 1'b1);
    chk(prog_counter, 32'h456);
    chk(irq, 1'b1);
    rchk(`REG_IRQ_CTRL, 32'h0004_0003);
    rchk(`REG_EVT_STATUS, 32'h5);
    i_host.wr(`REG_XREG, 32'h1111);
    i_host.wr(`REG_COND_FLAGS, 32'h22);
    settle(1);
    chk(irq, 1'b0);
    i_host.cmd(32'hbad, 32'h0, `OP_RETURN_HANDLER, 8'hff, 8'h00);
    settle(1);
    chk(in_handler, 1'b0);
    chk(prog_counter, 32'h77);
    rchk(`REG_ACCU, 32'hacce55);
    rchk(`REG_XREG, 32'h5a5a);
    rchk(`REG_COND_FLAGS, 32'h3c);
    i_host.cmd(0, 32'h0, `OP_IRQ_DISABLE, `IRQ_GLOBAL_NUM, 8'h00);
    pulse_src(2);
    settle(3);
    chk(in_handler, 1'b0);
    i_host.cmd(0, 32'h0, `OP_IRQ_DISABLE, 8'h02, 8'h00);
    rchk(`REG_IRQ_CTRL, 32'h0);
    i_host.cmd(0, 32'h0, `OP_IRQ_ENABLE, `IRQ_GLOBAL_NUM, 8'h00);
    settle(3);
    chk(in_handler, 1'b0);
    i_host.rd(8'h30, q, e);
    chk(e, 1'b1);
    chk(q, 32'h0);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rchk(`REG_IRQ_CTRL, 32'h0);
    rchk(`REG_REPLY, 32'h0);
    give_verdict;
  end
endmodule // tb

/* File: common/accu_cmd_defs.vh */
// Constants for the accumulator-transfer, error-clear and interrupt command unit
`ifndef ACCU_CMD_DEFS_VH
`define ACCU_CMD_DEFS_VH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_IRQ_ENABLE      8'h19
`define OP_IRQ_DISABLE     8'h1a
`define OP_ACCU_TO_AXIS    8'h22
`define OP_ACCU_TO_GLOBAL  8'h23
`define OP_CLEAR_ERRORS    8'h24
`define OP_DEFINE_ENTRY    8'h25
`define OP_RETURN_HANDLER  8'h26

// ----------------------------------------------------------------
// Field values
// ----------------------------------------------------------------
`define IRQ_GLOBAL_NUM     8'hff
`define BANK_AXIS_GLOBAL   8'h00
`define BANK_USER_VARS     8'h02
`define BANK_INTERRUPTS    8'h03
`define CLR_ALL            8'h00
`define CLR_LAST           8'h05
`define ERR_FLAG_N         5

// ----------------------------------------------------------------
// Reply status codes
// ----------------------------------------------------------------
`define STATUS_OK          8'h64
`define STATUS_BAD_CMD     8'h02
`define STATUS_BAD_TYPE    8'h03
`define STATUS_BAD_VALUE   8'h04
`define STATUS_IDLE        8'h00

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CMD            8'h00
`define REG_VALUE          8'h04
`define REG_REPLY          8'h08
`define REG_ACCU           8'h10
`define REG_XREG           8'h14
`define REG_COND_FLAGS     8'h18
`define REG_PROG_COUNTER   8'h1c
`define REG_ERR_FLAGS      8'h20
`define REG_IRQ_CTRL       8'h24
`define REG_EVT_STATUS     8'h28
`define REG_EVT_MASK       8'h2c

// ----------------------------------------------------------------
// Event status bit positions and reset values
// ----------------------------------------------------------------
`define EVT_CMD_DONE       0
`define EVT_CMD_ERROR      1
`define EVT_HANDLER_ENTRY  2
`define EVT_HANDLER_RETURN 3
`define EVT_N              4
`define RST_WORD           32'h0000_0000
`define RST_EVT_MASK       4'h0

`endif

/* File: core/accu_irq_cmd_unit.v */
// Command unit: accumulator transfers, error-flag clear and interrupt control
`timescale 1ns/1ps
`include "accu_cmd_defs.vh"
module accu_irq_cmd_unit #(
  parameter SRC_N = 16,
  parameter IDX_W = 4,
  parameter PC_W  = 16
) (
  input  wire                    clock,
  input  wire                    rst,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [7:0]              paddr,
  input  wire [31:0]             pwdata,
  output wire                    pready,
  output wire                    pslverr,
  output reg  [31:0]             prdata,
  input  wire [SRC_N-1:0]        irq_req,
  input  wire [`ERR_FLAG_N-1:0]  err_set,
  output reg                     axis_wr_stb,
  output reg  [7:0]              axis_wr_param,
  output reg  [7:0]              axis_wr_motor,
  output reg  [31:0]             axis_wr_data,
  output reg                     glob_wr_stb,
  output reg  [7:0]              glob_wr_param,
  output reg  [7:0]              glob_wr_bank,
  output reg  [31:0]             glob_wr_data,
  output wire [`ERR_FLAG_N-1:0]  err_flags,
  output wire [PC_W-1:0]         prog_counter,
  output wire                    in_handler,
  output wire                    irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [31:0]            accu_r;
  reg  [31:0]            xreg_r;
  reg  [7:0]             cflags_r;
  reg  [PC_W-1:0]        pc_r;
  reg  [31:0]            sv_accu_r;
  reg  [31:0]            sv_xreg_r;
  reg  [7:0]             sv_cflags_r;
  reg  [PC_W-1:0]        sv_pc_r;
  reg                    in_hdl_r;
  reg                    gie_r;
  reg  [31:0]            value_r;
  reg  [7:0]             rep_status_r;
  reg  [7:0]             rep_op_r;
  reg  [`ERR_FLAG_N-1:0] err_r;
  reg  [`ERR_FLAG_N-1:0] err_clr;
  reg  [`EVT_N-1:0]      evt_r;
  reg  [`EVT_N-1:0]      mask_r;
  reg  [`EVT_N-1:0]      evt_set;
  reg  [7:0]             status_nxt;
  reg                    ok;
  reg                    vec_wr;
  reg                    en_set;
  reg                    en_clr;
  reg                    gie_set;
  reg                    gie_clr;
  reg                    do_axis;
  reg                    do_glob;
  reg                    do_ret;
  reg  [31:0]            rd_nxt;
  reg                    mapped;

  wire                   acc_wr  = psel & penable & pwrite;
  wire                   acc_rd  = psel & penable & ~pwrite;
  wire                   cmd_go  = acc_wr & (paddr == `REG_CMD);
  wire [7:0]             op      = pwdata[7:0];
  wire [7:0]             typ     = pwdata[15:8];
  wire [7:0]             bank    = pwdata[23:16];
  wire                   src_ok  = (typ < SRC_N);
  wire [IDX_W-1:0]       sel_idx = typ[IDX_W-1:0];
  wire [SRC_N-1:0]       enables;
  wire                   pick_valid;
  wire [IDX_W-1:0]       pick_idx;
  wire [PC_W-1:0]        pick_addr;
  // Commands own the cycle; an interrupt waits one cycle behind them
  wire                   take = pick_valid & gie_r & ~in_hdl_r & ~cmd_go;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always @* begin
    ok      = 1'b0;
    vec_wr  = 1'b0;
    en_set  = 1'b0;
    en_clr  = 1'b0;
    gie_set = 1'b0;
    gie_clr = 1'b0;
    do_axis = 1'b0;
    do_glob = 1'b0;
    do_ret  = 1'b0;
    err_clr = {`ERR_FLAG_N{1'b0}};
    status_nxt = `STATUS_BAD_CMD;
    case (op)
      `OP_ACCU_TO_AXIS: begin
        do_axis = 1'b1;
        ok      = 1'b1;
      end
      `OP_ACCU_TO_GLOBAL: begin
        if (bank == `BANK_AXIS_GLOBAL || bank == `BANK_USER_VARS ||
            bank == `BANK_INTERRUPTS) begin
          do_glob = 1'b1;
          ok      = 1'b1;
        end else begin
          status_nxt = `STATUS_BAD_VALUE;
        end
      end
      `OP_CLEAR_ERRORS: begin
        if (typ == `CLR_ALL) begin
          err_clr = {`ERR_FLAG_N{1'b1}};
          ok      = 1'b1;
        end else if (typ <= `CLR_LAST) begin
          err_clr = 5'h01 << (typ[2:0] - 3'h1);
          ok      = 1'b1;
        end else begin
          status_nxt = `STATUS_BAD_TYPE;
        end
      end
      `OP_IRQ_ENABLE: begin
        if (typ == `IRQ_GLOBAL_NUM) begin
          gie_set = 1'b1;
          ok      = 1'b1;
        end else if (src_ok) begin
          en_set = 1'b1;
          ok     = 1'b1;
        end else begin
          status_nxt = `STATUS_BAD_TYPE;
        end
      end
      `OP_IRQ_DISABLE: begin
        if (typ == `IRQ_GLOBAL_NUM) begin
          gie_clr = 1'b1;
          ok      = 1'b1;
        end else if (src_ok) begin
          en_clr = 1'b1;
          ok     = 1'b1;
        end else begin
          status_nxt = `STATUS_BAD_TYPE;
        end
      end
      `OP_DEFINE_ENTRY: begin
        if (src_ok) begin
          vec_wr = 1'b1;
          ok     = 1'b1;
        end else begin
          status_nxt = `STATUS_BAD_TYPE;
        end
      end
      `OP_RETURN_HANDLER: begin
        // Return outside a handler would restore stale state, so refuse it
        if (in_hdl_r) begin
          do_ret = 1'b1;
          ok     = 1'b1;
        end
      end
      default: begin
        status_nxt = `STATUS_BAD_CMD;
      end
    endcase
    if (ok)
      status_nxt = `STATUS_OK;
  end

  handler_vector_table #(
    .SRC_N (SRC_N),
    .IDX_W (IDX_W),
    .PC_W  (PC_W)
  ) u_vec (
    .clock      (clock),
    .rst        (rst),
    .vec_wr     (cmd_go & vec_wr),
    .en_set     (cmd_go & en_set),
    .en_clr     (cmd_go & en_clr),
    .sel_idx    (sel_idx),
    .vec_addr   (value_r[PC_W-1:0]),
    .req        (irq_req),
    .take       (take),
    .enables    (enables),
    .defined    (),
    .pick_valid (pick_valid),
    .pick_idx   (pick_idx),
    .pick_addr  (pick_addr)
  );

  // ----------------------------------------------------------------
  // Execution, handler entry and return
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      accu_r       <= `RST_WORD;
      xreg_r       <= `RST_WORD;
      cflags_r     <= 8'h00;
      pc_r         <= {PC_W{1'b0}};
      sv_accu_r    <= `RST_WORD;
      sv_xreg_r    <= `RST_WORD;
      sv_cflags_r  <= 8'h00;
      sv_pc_r      <= {PC_W{1'b0}};
      in_hdl_r     <= 1'b0;
      gie_r        <= 1'b0;
      value_r      <= `RST_WORD;
      rep_status_r <= `STATUS_IDLE;
      rep_op_r     <= 8'h00;
      axis_wr_stb  <= 1'b0;
      axis_wr_param <= 8'h00;
      axis_wr_motor <= 8'h00;
      axis_wr_data <= `RST_WORD;
      glob_wr_stb  <= 1'b0;
      glob_wr_param <= 8'h00;
      glob_wr_bank <= 8'h00;
      glob_wr_data <= `RST_WORD;
    end else begin
      axis_wr_stb <= cmd_go & do_axis;
      glob_wr_stb <= cmd_go & do_glob;
      if (acc_wr && paddr == `REG_VALUE)
        value_r <= pwdata;
      if (acc_wr && paddr == `REG_ACCU)
        accu_r <= pwdata;
      if (acc_wr && paddr == `REG_XREG)
        xreg_r <= pwdata;
      if (acc_wr && paddr == `REG_COND_FLAGS)
        cflags_r <= pwdata[7:0];
      if (acc_wr && paddr == `REG_PROG_COUNTER)
        pc_r <= pwdata[PC_W-1:0];
      if (cmd_go) begin
        rep_status_r <= status_nxt;
        rep_op_r     <= op;
        if (do_axis) begin
          axis_wr_param <= typ;
          axis_wr_motor <= bank;
          axis_wr_data  <= accu_r;
        end
        if (do_glob) begin
          glob_wr_param <= typ;
          glob_wr_bank  <= bank;
          glob_wr_data  <= accu_r;
        end
        if (gie_set)
          gie_r <= 1'b1;
        if (gie_clr)
          gie_r <= 1'b0;
        if (do_ret) begin
          accu_r   <= sv_accu_r;
          xreg_r   <= sv_xreg_r;
          cflags_r <= sv_cflags_r;
          pc_r     <= sv_pc_r;
          in_hdl_r <= 1'b0;
        end
      end else if (take) begin
        sv_accu_r   <= accu_r;
        sv_xreg_r   <= xreg_r;
        sv_cflags_r <= cflags_r;
        sv_pc_r     <= pc_r;
        pc_r        <= pick_addr;
        in_hdl_r    <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Error flags: a new error wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst)
      err_r <= {`ERR_FLAG_N{1'b0}};
    else
      err_r <= (err_r & ~(cmd_go ? err_clr : {`ERR_FLAG_N{1'b0}})) | err_set;
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt line
  // ----------------------------------------------------------------
  always @* begin
    evt_set = {`EVT_N{1'b0}};
    evt_set[`EVT_CMD_DONE]       = cmd_go & ok;
    evt_set[`EVT_CMD_ERROR]      = cmd_go & ~ok;
    evt_set[`EVT_HANDLER_ENTRY]  = take;
    evt_set[`EVT_HANDLER_RETURN] = cmd_go & do_ret;
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      evt_r  <= {`EVT_N{1'b0}};
      mask_r <= `RST_EVT_MASK;
    end else begin
      // Clear only what the setup cycle captured; a later event survives
      if (acc_rd && paddr == `REG_EVT_STATUS)
        evt_r <= (evt_r & ~prdata[`EVT_N-1:0]) | evt_set;
      else
        evt_r <= evt_r | evt_set;
      if (acc_wr && paddr == `REG_EVT_MASK)
        mask_r <= pwdata[`EVT_N-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Register read; data captured in the setup cycle
  // ----------------------------------------------------------------
  always @* begin
    rd_nxt = `RST_WORD;
    mapped = 1'b1;
    case (paddr)
      `REG_CMD:          rd_nxt = {24'h000000, rep_op_r};
      `REG_VALUE:        rd_nxt = value_r;
      `REG_REPLY:        rd_nxt = {16'h0000, rep_op_r, rep_status_r};
      `REG_ACCU:         rd_nxt = accu_r;
      `REG_XREG:         rd_nxt = xreg_r;
      `REG_COND_FLAGS:   rd_nxt = {24'h000000, cflags_r};
      `REG_PROG_COUNTER: rd_nxt[PC_W-1:0] = pc_r;
      `REG_ERR_FLAGS:    rd_nxt[`ERR_FLAG_N-1:0] = err_r;
      `REG_IRQ_CTRL: begin
        rd_nxt[0] = gie_r;
        rd_nxt[1] = in_hdl_r;
        rd_nxt[16 +: SRC_N] = enables;
      end
      `REG_EVT_STATUS:   rd_nxt[`EVT_N-1:0] = evt_r;
      `REG_EVT_MASK:     rd_nxt[`EVT_N-1:0] = mask_r;
      default:           mapped = 1'b0;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst)
      prdata <= `RST_WORD;
    else if (psel && !penable)
      prdata <= rd_nxt;
  end

  // Zero wait states; unmapped offsets answer with an error
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~mapped;
  assign err_flags    = err_r;
  assign prog_counter = pc_r;
  assign in_handler   = in_hdl_r;
  assign irq          = |(evt_r & mask_r);

endmodule // accu_irq_cmd_unit

/* File: core/handler_vector_table.v */
// Per-source interrupt enables, handler entry vectors and pending requests
`timescale 1ns/1ps
module handler_vector_table #(
  parameter SRC_N = 16,
  parameter IDX_W = 4,
  parameter PC_W  = 16
) (
  input  wire                   clock,
  input  wire                   rst,
  input  wire                   vec_wr,
  input  wire                   en_set,
  input  wire                   en_clr,
  input  wire [IDX_W-1:0]       sel_idx,
  input  wire [PC_W-1:0]        vec_addr,
  input  wire [SRC_N-1:0]       req,
  input  wire                   take,
  output wire [SRC_N-1:0]       enables,
  output wire [SRC_N-1:0]       defined,
  output reg                    pick_valid,
  output reg  [IDX_W-1:0]       pick_idx,
  output reg  [PC_W-1:0]        pick_addr
);

  wire [SRC_N-1:0]      pend;
  wire [SRC_N*PC_W-1:0] vec_flat;
  integer               i;

  // ----------------------------------------------------------------
  // One entry per interrupt source
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < SRC_N; k = k + 1) begin : g_ent
      reg [PC_W-1:0] vec_r;
      reg            def_r;
      reg            en_r;
      reg            pend_r;
      wire           hit = (sel_idx == k[IDX_W-1:0]);
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          vec_r  <= {PC_W{1'b0}};
          def_r  <= 1'b0;
          en_r   <= 1'b0;
          pend_r <= 1'b0;
        end else begin
          if (vec_wr && hit) begin
            vec_r <= vec_addr;
            def_r <= 1'b1;
          end
          if (en_set && hit)
            en_r <= 1'b1;
          else if (en_clr && hit)
            en_r <= 1'b0;
          // New request wins over the clear of the one just taken
          if (req[k])
            pend_r <= 1'b1;
          else if (take && pick_idx == k[IDX_W-1:0])
            pend_r <= 1'b0;
        end
      end
      assign enables[k] = en_r;
      assign defined[k] = def_r;
      assign pend[k]    = pend_r;
      assign vec_flat[k*PC_W +: PC_W] = vec_r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Lowest numbered eligible source wins
  // ----------------------------------------------------------------
  always @* begin
    pick_valid = 1'b0;
    pick_idx   = {IDX_W{1'b0}};
    pick_addr  = {PC_W{1'b0}};
    for (i = SRC_N - 1; i >= 0; i = i - 1) begin
      if (pend[i] && enables[i] && defined[i]) begin
        pick_valid = 1'b1;
        pick_idx   = i[IDX_W-1:0];
        pick_addr  = vec_flat[i*PC_W +: PC_W];
      end
    end
  end

endmodule // handler_vector_table
